// ### cies_call_stack.sv
// Hardware return stack, circular, with a saturating fill count.
// Assumes push and pop are never raised together.
`timescale 1ns/1ps
`include "cies_defines.svh"
module cies_call_stack (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic [11:0] i_push_data,
  output logic [11:0] o_top,
  output logic [2:0] o_level
);
  import cies_pkg::*;

  logic [11:0] entry_reg [`CIES_STACK_DEPTH];
  logic [1:0] ptr_reg;

  // Overflow wraps and overwrites the oldest entry, as small cores do.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ptr_reg <= 2'h0;
    end else if (i_push) begin
      entry_reg[2'(ptr_reg + 2'h1)] <= i_push_data;
      ptr_reg <= 2'(ptr_reg + 2'h1);
    end else if (i_pop) begin
      ptr_reg <= 2'(ptr_reg - 2'h1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_level <= 3'h0;
    end else if (i_push && o_level != 3'(`CIES_STACK_DEPTH)) begin
      o_level <= 3'(o_level + 3'h1);
    end else if (i_pop && o_level != 3'h0) begin
      o_level <= 3'(o_level - 3'h1);
    end
  end

  assign o_top = entry_reg[ptr_reg];
endmodule : cies_call_stack

// ### cies_core.sv
// Instruction execution core for a subset of a 14-bit instruction set.
// Assumes a single-cycle register bus master on the same clock and a
// wake pin that is asynchronous to the clock.
`timescale 1ns/1ps
`include "cies_defines.svh"
module cies_core (
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  input wire cies_pkg::cies_bus_s I_BUS,
  input wire logic I_WAKE,
  output logic [7:0] O_RD_DATA,
  output logic O_BUSY,
  output logic O_OSC_STOP,
  output logic [11:0] O_PROG_COUNTER,
  output logic O_IRQ_ENABLE
);
  import cies_pkg::*;

  // -----------------------------------------------------------------
  // Decode
  // -----------------------------------------------------------------
  function automatic cies_op_e decode_op(input logic [13:0] w);
    cies_op_e op;
    op = OP_OTHER;
    if (w == `CIES_W_NOP) begin
      op = OP_NOP;
    end else if (w == `CIES_W_SLEEP) begin
      op = OP_POWER_DOWN;
    end else if (w == `CIES_W_RETURN) begin
      op = OP_RETURN_SUB;
    end else if (w == `CIES_W_RETURN_IRQ) begin
      op = OP_RETURN_IRQ;
    end else if (w == `CIES_W_WDT_CLEAR) begin
      op = OP_OTHER;
    end else if (w[13:6] == 8'h00) begin
      op = OP_ACC_TO_SPECIAL;
    end else if (w[13:7] == 7'h01) begin
      op = OP_ACC_TO_FILE;
    end else if (w[13:12] == `CIES_P_CALL) begin
      op = OP_CALL;
    end else begin
      case (w[13:8])
        `CIES_P_SUB: op = OP_SUB_FILE;
        `CIES_P_OR_FILE: op = OP_OR_FILE;
        `CIES_P_XOR_FILE: op = OP_XOR_FILE;
        `CIES_P_MOVE_TEST: op = w[7] ? OP_TEST_ZERO : OP_FILE_TO_ACC;
        `CIES_P_ROT_RIGHT: op = OP_ROT_RIGHT;
        `CIES_P_ROT_LEFT: op = OP_ROT_LEFT;
        `CIES_P_SWAP: op = OP_SWAP;
        `CIES_P_INC_SKIP: op = OP_INC_SKIP;
        `CIES_P_RETURN_LIT: op = OP_RETURN_LIT;
        `CIES_P_LIT_ACC: op = OP_LIT_TO_ACC;
        `CIES_P_OR_LIT: op = OP_OR_LIT;
        `CIES_P_XOR_LIT: op = OP_XOR_LIT;
        default: op = OP_OTHER;
      endcase
    end
    return op;
  endfunction : decode_op

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  cies_state_e state_reg;
  cies_op_e op_reg;
  cies_flags_s flags_reg;
  cies_flags_s flags_next;
  logic [7:0] instr_lo_reg;
  logic [13:0] instr_reg;
  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  logic [11:0] pcnt_reg;
  logic [11:0] pcnt_next;
  logic osc_stop_reg;
  logic wake_meta_reg;
  logic wake_sync_reg;
  logic [7:0] ram_q;
  logic ram_we;
  logic [6:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic [11:0] stack_top;
  logic [2:0] stack_level;
  logic push;
  logic pop;
  logic two_cycle;
  logic use_dest;
  logic [7:0] res;
  logic [8:0] diff;
  logic [4:0] ndiff;
  logic issue;
  logic sw_wr;

  wire exec = (state_reg == ST_EXEC);
  wire [7:0] lit = instr_reg[7:0];
  wire dest_file = instr_reg[7];

  // Software may only write registers while no instruction runs.
  assign sw_wr = I_BUS.wr && (state_reg == ST_IDLE);
  assign issue = sw_wr && !osc_stop_reg
      && I_BUS.addr == `CIES_ADDR_INSTR_HI;

  cies_file_ram u_file_ram (
    .i_clk(I_MCLK),
    .i_rst(I_SYS_RST),
    .i_we(ram_we),
    .i_waddr(ram_waddr),
    .i_wdata(ram_wdata),
    .i_raddr(instr_lo_reg[6:0]),
    .o_rdata(ram_q)
  );

  cies_call_stack u_call_stack (
    .i_clk(I_MCLK),
    .i_rst(I_SYS_RST),
    .i_push(push),
    .i_pop(pop),
    .i_push_data(12'(pcnt_reg + 12'h001)),
    .o_top(stack_top),
    .o_level(stack_level)
  );

  // -----------------------------------------------------------------
  // Execute
  // -----------------------------------------------------------------
  always_comb begin
    diff = 9'({1'b0, ram_q} - {1'b0, acc_reg});
    ndiff = 5'({1'b0, ram_q[3:0]} - {1'b0, acc_reg[3:0]});
    res = 8'h00;
    use_dest = 1'b0;
    two_cycle = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    acc_next = acc_reg;
    flags_next = flags_reg;
    pcnt_next = 12'(pcnt_reg + 12'h001);
    ram_we = 1'b0;
    ram_waddr = instr_reg[6:0];
    ram_wdata = acc_reg;
    if (exec) begin
      unique case (op_reg)
        OP_NOP, OP_OTHER: begin
          res = 8'h00;
        end
        OP_POWER_DOWN: begin
          flags_next.timeout = 1'b1;
          flags_next.pdown = 1'b0;
        end
        OP_RETURN_SUB: begin
          pop = 1'b1;
          two_cycle = 1'b1;
          pcnt_next = stack_top;
        end
        OP_RETURN_IRQ: begin
          pop = 1'b1;
          two_cycle = 1'b1;
          pcnt_next = stack_top;
          flags_next.irq_en = 1'b1;
        end
        OP_RETURN_LIT: begin
          pop = 1'b1;
          two_cycle = 1'b1;
          pcnt_next = stack_top;
          acc_next = lit;
        end
        OP_CALL: begin
          push = 1'b1;
          two_cycle = 1'b1;
          pcnt_next = instr_reg[11:0];
        end
        OP_ACC_TO_SPECIAL: begin
          ram_we = 1'b1;
          ram_waddr = {1'b0, instr_reg[5:0]};
        end
        OP_ACC_TO_FILE: begin
          ram_we = 1'b1;
        end
        OP_FILE_TO_ACC: begin
          acc_next = ram_q;
        end
        OP_LIT_TO_ACC: begin
          acc_next = lit;
        end
        OP_TEST_ZERO: begin
          flags_next.zero = (ram_q == 8'h00);
        end
        OP_SUB_FILE: begin
          res = diff[7:0];
          use_dest = 1'b1;
          flags_next.carry = !diff[8];
          flags_next.dcarry = !ndiff[4];
        end
        OP_OR_FILE: begin
          res = acc_reg | ram_q;
          use_dest = 1'b1;
        end
        OP_XOR_FILE: begin
          res = acc_reg ^ ram_q;
          use_dest = 1'b1;
        end
        OP_ROT_LEFT: begin
          res = {ram_q[6:0], flags_reg.carry};
          use_dest = 1'b1;
          flags_next.carry = ram_q[7];
        end
        OP_ROT_RIGHT: begin
          res = {flags_reg.carry, ram_q[7:1]};
          use_dest = 1'b1;
          flags_next.carry = ram_q[0];
        end
        OP_SWAP: begin
          res = {ram_q[3:0], ram_q[7:4]};
          use_dest = 1'b1;
        end
        OP_INC_SKIP: begin
          res = 8'(ram_q + 8'h01);
          use_dest = 1'b1;
          if (res == 8'h00) begin
            two_cycle = 1'b1;
            pcnt_next = 12'(pcnt_reg + 12'h002);
          end
        end
        OP_OR_LIT: begin
          acc_next = acc_reg | lit;
        end
        OP_XOR_LIT: begin
          acc_next = acc_reg ^ lit;
        end
      endcase
      // Zero flag from OR, XOR and subtract results.
      if (op_reg == OP_OR_LIT || op_reg == OP_XOR_LIT) begin
        flags_next.zero = (acc_next == 8'h00);
      end else if (op_reg == OP_SUB_FILE || op_reg == OP_OR_FILE
          || op_reg == OP_XOR_FILE) begin
        flags_next.zero = (res == 8'h00);
      end
      if (use_dest) begin
        if (dest_file) begin
          ram_we = 1'b1;
          ram_wdata = res;
        end else begin
          acc_next = res;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Sequencing
  // -----------------------------------------------------------------
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: state_reg <= issue ? ST_EXEC : ST_IDLE;
        ST_EXEC: state_reg <= two_cycle ? ST_SECOND : ST_IDLE;
        ST_SECOND: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      instr_lo_reg <= 8'h00;
      instr_reg <= `CIES_W_NOP;
      op_reg <= OP_NOP;
    end else if (issue) begin
      instr_reg <= {I_BUS.wr_data[5:0], instr_lo_reg};
      op_reg <= decode_op({I_BUS.wr_data[5:0], instr_lo_reg});
    end else if (sw_wr && I_BUS.addr == `CIES_ADDR_INSTR_LO) begin
      instr_lo_reg <= I_BUS.wr_data;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      acc_reg <= `CIES_RST_ACC;
    end else if (exec) begin
      acc_reg <= acc_next;
    end else if (sw_wr && I_BUS.addr == `CIES_ADDR_ACC) begin
      acc_reg <= I_BUS.wr_data;
    end
  end

  // Timeout and power-down flags are read-only to software.
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      flags_reg <= `CIES_RST_FLAGS;
    end else if (exec) begin
      flags_reg <= flags_next;
    end else if (sw_wr && I_BUS.addr == `CIES_ADDR_STATUS) begin
      flags_reg.carry <= I_BUS.wr_data[`CIES_BIT_CARRY];
      flags_reg.dcarry <= I_BUS.wr_data[`CIES_BIT_DCARRY];
      flags_reg.zero <= I_BUS.wr_data[`CIES_BIT_ZERO];
      flags_reg.irq_en <= I_BUS.wr_data[`CIES_BIT_IRQEN];
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      pcnt_reg <= `CIES_RST_PCNT;
    end else if (exec) begin
      pcnt_reg <= pcnt_next;
    end else if (sw_wr && I_BUS.addr == `CIES_ADDR_PCNT_LO) begin
      pcnt_reg[7:0] <= I_BUS.wr_data;
    end else if (sw_wr && I_BUS.addr == `CIES_ADDR_PCNT_HI) begin
      pcnt_reg[11:8] <= I_BUS.wr_data[3:0];
    end
  end

  // -----------------------------------------------------------------
  // Power-down and wake
  // -----------------------------------------------------------------
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
    end else begin
      wake_meta_reg <= I_WAKE;
      wake_sync_reg <= wake_meta_reg;
    end
  end

  // A wake level held from before the sleep would restart at once, so
  // software must release the pin before issuing the power-down word.
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      osc_stop_reg <= 1'b0;
    end else if (exec && op_reg == OP_POWER_DOWN) begin
      osc_stop_reg <= 1'b1;
    end else if (wake_sync_reg) begin
      osc_stop_reg <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Read port and outputs
  // -----------------------------------------------------------------
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      O_RD_DATA <= 8'h00;
    end else if (I_BUS.rd) begin
      unique case (I_BUS.addr)
        `CIES_ADDR_INSTR_LO: O_RD_DATA <= instr_lo_reg;
        `CIES_ADDR_INSTR_HI: O_RD_DATA <= {2'b00, instr_reg[13:8]};
        `CIES_ADDR_ACC: O_RD_DATA <= acc_reg;
        `CIES_ADDR_STATUS: O_RD_DATA <= {state_reg != ST_IDLE,
            osc_stop_reg, flags_reg};
        `CIES_ADDR_PCNT_LO: O_RD_DATA <= pcnt_reg[7:0];
        `CIES_ADDR_PCNT_HI: O_RD_DATA <= {4'h0, pcnt_reg[11:8]};
        `CIES_ADDR_STACK_LVL: O_RD_DATA <= {5'h00, stack_level};
        default: O_RD_DATA <= 8'h00;
      endcase
    end else begin
      O_RD_DATA <= 8'h00;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      O_BUSY <= 1'b0;
      O_OSC_STOP <= 1'b0;
      O_PROG_COUNTER <= `CIES_RST_PCNT;
      O_IRQ_ENABLE <= 1'b0;
    end else begin
      O_BUSY <= (state_reg == ST_IDLE) ? issue : (exec && two_cycle);
      O_OSC_STOP <= osc_stop_reg;
      O_PROG_COUNTER <= pcnt_reg;
      O_IRQ_ENABLE <= flags_reg.irq_en;
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SYS_RST);

  chk_inc_skip_zero: assert property (
    exec && op_reg == OP_INC_SKIP && ram_q == 8'hFF |=>
    pcnt_reg == 12'($past(pcnt_reg) + 12'h002)
    && state_reg == ST_SECOND ##1 state_reg == ST_IDLE)
    else $error("skip did not advance by two in two cycles");

  chk_dest_acc: assert property (
    exec && op_reg == OP_SWAP && !dest_file |=>
    acc_reg == {$past(ram_q[3:0]), $past(ram_q[7:4])})
    else $error("destination zero did not reach accumulator");

  chk_or_lit_zero: assert property (
    exec && op_reg == OP_OR_LIT |=>
    acc_reg == ($past(acc_reg) | $past(lit))
    && flags_reg.zero == (acc_reg == 8'h00) && state_reg == ST_IDLE)
    else $error("literal OR result or zero flag wrong");

  chk_file_acc_flags: assert property (
    exec && op_reg == OP_FILE_TO_ACC |=>
    acc_reg == $past(ram_q) && $stable(flags_reg))
    else $error("file move wrong or flags changed");

  chk_acc_file_write: assert property (
    exec && op_reg == OP_ACC_TO_FILE |->
    ram_we && ram_wdata == acc_reg && ram_waddr == instr_reg[6:0])
    else $error("accumulator not written to file");

  chk_nop_quiet: assert property (
    exec && op_reg == OP_NOP |=> $stable(acc_reg) && $stable(flags_reg)
    && pcnt_reg == 12'($past(pcnt_reg) + 12'h001)
    && state_reg == ST_IDLE)
    else $error("no-operation changed state");

  chk_return_pop: assert property (
    exec && op_reg == OP_RETURN_SUB |=>
    pcnt_reg == $past(stack_top) && state_reg == ST_SECOND
    ##1 state_reg == ST_IDLE)
    else $error("return did not pop into counter");

  chk_irq_return: assert property (
    exec && op_reg == OP_RETURN_IRQ |=> flags_reg.irq_en ##1 O_IRQ_ENABLE)
    else $error("interrupt return left interrupts off");

  chk_power_down: assert property (
    exec && op_reg == OP_POWER_DOWN |=> osc_stop_reg
    && flags_reg.timeout && !flags_reg.pdown)
    else $error("power-down not entered");

  chk_sub_borrow: assert property (
    exec && op_reg == OP_SUB_FILE |=>
    flags_reg.carry == ($past(ram_q) >= $past(acc_reg)))
    else $error("subtract carry wrong");

  chk_call_push: assert property (
    exec && op_reg == OP_CALL && stack_level != 3'h4 |=>
    pcnt_reg == $past(instr_reg[11:0])
    && stack_top == 12'($past(pcnt_reg) + 12'h001)
    && stack_level == 3'($past(stack_level) + 3'h1))
    else $error("call did not push return address");
endmodule : cies_core

// ### cies_core_tb.sv
// Self-checking bench for the instruction execution core.
// Assumes one clock and the single-cycle register bus of the core.
`timescale 1ns/1ps
module cies_core_tb;
  import cies_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wake = 1'b0;
  cies_bus_s bus = '0;
  logic [7:0] rdata;
  logic busy;
  logic osc;
  logic irq;
  logic [11:0] pc;
  int fails = 0;
  int check_count = 0;
  logic [7:0] sf [3] = '{8'h03, 8'h02, 8'h01};
  logic [7:0] sres [3] = '{8'h01, 8'h00, 8'hFF};
  logic [7:0] sst [3] = '{8'h03, 8'h07, 8'h00};
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end

  always #5 clk = ~clk;

  cies_core uut (.I_MCLK(clk), .I_SYS_RST(rst), .I_BUS(bus), .I_WAKE(wake),
    .O_RD_DATA(rdata), .O_BUSY(busy), .O_OSC_STOP(osc), .O_PROG_COUNTER(pc),
    .O_IRQ_ENABLE(irq));

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk) bus <= {a, v, 2'b10};
    @(posedge clk) bus <= '0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge clk) bus <= {a, 8'h00, 2'b01};
    @(posedge clk) bus <= '0;
    #1 `CHK(rdata & m, e)
  endtask : rd

  // The busy wait is bounded, so a hung core shows up as a wrong count.
  task automatic op(input logic [13:0] w, input int n);
    int c;
    c = 0;
    wr(8'h00, w[7:0]);
    wr(8'h01, {2'b00, w[13:8]});
    for (int i = 0; i < 8; i++) begin
      #1;
      if (busy === 1'b1) c++;
      else if (c > 0) break;
      @(posedge clk);
    end
    `CHK(c, n)
  endtask : op

  function automatic logic [13:0] fw(input logic [5:0] p, input logic d, input logic [6:0] f);
    return {p, d, f};
  endfunction : fw

  task automatic setf(input logic [6:0] f, input logic [7:0] v);
    op({6'h19, v}, 1);
    op({7'h01, f}, 1);
  endtask : setf

  task automatic results;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  // -----------------------------------------------------------------
  // Stimulus
  // -----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(8'h03, 8'h18);
    rd(8'h02, 8'h00);
    op({6'h19, 8'h9A}, 1);
    op({6'h1A, 8'h35}, 1);
    rd(8'h02, 8'hBF);
    rd(8'h03, 8'h00, 8'h04);
    op({6'h1F, 8'hBF}, 1);
    rd(8'h03, 8'h04, 8'h04);
    op({6'h19, 8'hB5}, 1);
    rd(8'h03, 8'h04, 8'h04);
    rd(8'h02, 8'hB5);
    $display("literal test done");
    setf(7'h11, 8'hAF);
    op({6'h19, 8'hB5}, 1);
    op(fw(6'h06, 1'b1, 7'h11), 1);
    rd(8'h02, 8'hB5);
    op(fw(6'h08, 1'b0, 7'h11), 1);
    rd(8'h02, 8'h1A);
    setf(7'h12, 8'h13);
    op({6'h19, 8'h91}, 1);
    op(fw(6'h04, 1'b0, 7'h12), 1);
    rd(8'h02, 8'h93);
    op({8'h00, 6'h3F}, 1);
    op({6'h19, 8'h00}, 1);
    op(fw(6'h08, 1'b0, 7'h3F), 1);
    rd(8'h02, 8'h93);
    setf(7'h13, 8'hA5);
    op(fw(6'h0E, 1'b0, 7'h13), 1);
    rd(8'h02, 8'h5A);
    setf(7'h14, 8'h00);
    wr(8'h03, 8'h00);
    op(fw(6'h08, 1'b1, 7'h14), 1);
    rd(8'h03, 8'h04, 8'h04);
    op(fw(6'h08, 1'b1, 7'h13), 1);
    rd(8'h03, 8'h00, 8'h04);
    rd(8'h02, 8'h00);
    $display("file test done");
    for (int i = 0; i < 3; i++) begin
      setf(7'h15, sf[i]);
      op({6'h19, 8'h02}, 1);
      op(fw(6'h02, 1'b1, 7'h15), 1);
      rd(8'h03, sst[i], 8'h07);
      op(fw(6'h08, 1'b0, 7'h15), 1);
      rd(8'h02, sres[i]);
    end
    setf(7'h16, 8'hE6);
    wr(8'h03, 8'h00);
    op(fw(6'h0D, 1'b0, 7'h16), 1);
    rd(8'h02, 8'hCC);
    rd(8'h03, 8'h01, 8'h01);
    op(fw(6'h0C, 1'b0, 7'h16), 1);
    rd(8'h02, 8'hF3);
    rd(8'h03, 8'h00, 8'h01);
    $display("arith test done");
    setf(7'h17, 8'hFF);
    wr(8'h04, 8'h40);
    wr(8'h05, 8'h00);
    op(fw(6'h0F, 1'b1, 7'h17), 2);
    op(14'h0000, 1);
    rd(8'h04, 8'h43);
    op(fw(6'h0F, 1'b0, 7'h17), 1);
    rd(8'h02, 8'h01);
    op({2'b10, 12'h123}, 2);
    rd(8'h04, 8'h23);
    rd(8'h06, 8'h01);
    op(14'h0040, 2);
    rd(8'h04, 8'h45);
    rd(8'h06, 8'h00);
    op({2'b10, 12'h200}, 2);
    op({6'h18, 8'h77}, 2);
    rd(8'h02, 8'h77);
    rd(8'h04, 8'h46);
    op({2'b10, 12'h300}, 2);
    op(14'h0060, 2);
    rd(8'h03, 8'h20, 8'h20);
    `CHK(irq, 1'b1)
    `CHK(pc, 12'h047)
    $display("flow test done");
    op(14'h0003, 1);
    rd(8'h03, 8'h50, 8'h58);
    `CHK(osc, 1'b1)
    op(14'h0000, 0);
    @(posedge clk) wake <= 1'b1;
    repeat (4) @(posedge clk);
    wake <= 1'b0;
    repeat (4) @(posedge clk);
    #1 `CHK(osc, 1'b0)
    rd(8'h03, 8'h00, 8'h40);
    $display("power test done");
    results();
  end
endmodule : cies_core_tb

// ### cies_defines.svh
// Constants of the instruction execution block: register map, field
// positions, reset values and opcode encodings.
// Assumes inclusion by cies_pkg and by each design module, under its guard.
`ifndef CIES_DEFINES_SVH
`define CIES_DEFINES_SVH

// -----------------------------------------------------------------
// Register map
// -----------------------------------------------------------------
`define CIES_ADDR_INSTR_LO 8'h00
`define CIES_ADDR_INSTR_HI 8'h01
`define CIES_ADDR_ACC 8'h02
`define CIES_ADDR_STATUS 8'h03
`define CIES_ADDR_PCNT_LO 8'h04
`define CIES_ADDR_PCNT_HI 8'h05
`define CIES_ADDR_STACK_LVL 8'h06

// -----------------------------------------------------------------
// Status bit positions and reset values
// -----------------------------------------------------------------
`define CIES_BIT_CARRY 0
`define CIES_BIT_DCARRY 1
`define CIES_BIT_ZERO 2
`define CIES_BIT_PDOWN 3
`define CIES_BIT_TMOUT 4
`define CIES_BIT_IRQEN 5
`define CIES_BIT_ASLEEP 6
`define CIES_BIT_BUSY 7
`define CIES_RST_ACC 8'h00
`define CIES_RST_PCNT 12'h000
`define CIES_RST_FLAGS 6'h18

// -----------------------------------------------------------------
// Opcodes and sizes
// -----------------------------------------------------------------
`define CIES_W_NOP 14'h0000
`define CIES_W_SLEEP 14'h0003
`define CIES_W_WDT_CLEAR 14'h0004
`define CIES_W_RETURN 14'h0040
`define CIES_W_RETURN_IRQ 14'h0060
`define CIES_P_SUB 6'h02
`define CIES_P_OR_FILE 6'h04
`define CIES_P_XOR_FILE 6'h06
`define CIES_P_MOVE_TEST 6'h08
`define CIES_P_ROT_RIGHT 6'h0C
`define CIES_P_ROT_LEFT 6'h0D
`define CIES_P_SWAP 6'h0E
`define CIES_P_INC_SKIP 6'h0F
`define CIES_P_RETURN_LIT 6'h18
`define CIES_P_LIT_ACC 6'h19
`define CIES_P_OR_LIT 6'h1A
`define CIES_P_XOR_LIT 6'h1F
`define CIES_P_CALL 2'b10
`define CIES_STACK_DEPTH 4
`define CIES_FILE_WORDS 128

`endif

// ### cies_file_ram.sv
// File register memory, one write port and one registered read port.
// Assumes a single clock shared with the core.
`timescale 1ns/1ps
`include "cies_defines.svh"
module cies_file_ram (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [6:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [6:0] i_raddr,
  output logic [7:0] o_rdata
);
  import cies_pkg::*;

  logic [7:0] mem [`CIES_FILE_WORDS];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Read data come from a register so the core sees them one cycle on.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule : cies_file_ram

// ### cies_pkg.sv
// Types shared by the instruction execution block.
// Assumes cies_defines.svh is on the include path.
package cies_pkg;
`include "cies_defines.svh"

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_POWER_DOWN = 5'h01, OP_RETURN_SUB = 5'h02,
    OP_RETURN_IRQ = 5'h03, OP_ACC_TO_SPECIAL = 5'h04,
    OP_ACC_TO_FILE = 5'h05, OP_SUB_FILE = 5'h06, OP_OR_FILE = 5'h07,
    OP_XOR_FILE = 5'h08, OP_FILE_TO_ACC = 5'h09, OP_TEST_ZERO = 5'h0A,
    OP_ROT_RIGHT = 5'h0B, OP_ROT_LEFT = 5'h0C, OP_SWAP = 5'h0D,
    OP_INC_SKIP = 5'h0E, OP_RETURN_LIT = 5'h0F, OP_LIT_TO_ACC = 5'h10,
    OP_OR_LIT = 5'h11, OP_XOR_LIT = 5'h12, OP_CALL = 5'h13,
    OP_OTHER = 5'h14
  } cies_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_SECOND = 2'b10
  } cies_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic wr;
    logic rd;
  } cies_bus_s;

  typedef struct packed {
    logic irq_en;
    logic timeout;
    logic pdown;
    logic zero;
    logic dcarry;
    logic carry;
  } cies_flags_s;
endpackage : cies_pkg
